//--- logic/uas_aux_regs.svh
// Register offsets, field positions and reset values of the auxiliary register slice
`ifndef UAS_AUX_REGS_SVH
`define UAS_AUX_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define UAS_OFF_MODEM_STATUS 8'h18
`define UAS_OFF_SCRATCH 8'h1C
`define UAS_OFF_LP_DIV_LOW 8'h20
`define UAS_OFF_LP_DIV_HIGH 8'h24
`define UAS_OFF_ALIAS_FIRST 8'h30
`define UAS_OFF_ALIAS_LAST 8'h6C
`define UAS_OFF_TEST_ENABLE 8'h70
`define UAS_OFF_TX_TEST_READ 8'h74
`define UAS_OFF_RX_TEST_WRITE 8'h78
`define UAS_OFF_INT_STATUS 8'h90
`define UAS_OFF_INT_MASK 8'h94

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UAS_MSTAT_CTS_CHANGED 0
`define UAS_MSTAT_CTS_LEVEL 4
`define UAS_TEST_ENABLE_BIT 0
`define UAS_RXTEST_PARITY 8
`define UAS_RXTEST_FRAMING 9
`define UAS_INT_CTS 0
`define UAS_INT_DLAB_CLASH 1
`define UAS_INT_RX_EMPTY 2
`define UAS_INT_TX_FULL 3
`define UAS_INT_BITS 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UAS_RST_BYTE 8'h00
`define UAS_RST_TEST_ENABLE 1'h0
`define UAS_RST_INT 4'h0
`define UAS_RST_WORD 32'h00000000

`endif

//--- logic/uas_pkg.sv
// Types shared by the auxiliary register slice
package uas_pkg;

  // One data byte of the serial path
  typedef logic [7:0] uas_byte_t;

  // Register selected by a bus address
  typedef enum logic [3:0] {
    REGION_NONE,
    REGION_MODEM,
    REGION_SCRATCH,
    REGION_LP_LOW,
    REGION_LP_HIGH,
    REGION_ALIAS,
    REGION_TEST_EN,
    REGION_TX_TEST,
    REGION_RX_TEST,
    REGION_INT_STAT,
    REGION_INT_MASK
  } uas_region_e;

endpackage

//--- logic/uas_change_detect.sv
// Level change detector with sticky per-line flags
`timescale 1ns/1ps
module uas_change_detect #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Watched levels
  input wire logic [WIDTH-1:0] level,
  // Clear request, one cycle
  input wire logic clear,
  // Sticky change flags and change pulses
  output logic [WIDTH-1:0] changed_q,
  output logic [WIDTH-1:0] edge_q
);

  // Last seen level of each line
  logic [WIDTH-1:0] last_q;

  // Refused at elaboration, before any vector gets a negative width
  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("uas_change_detect: WIDTH must be at least 1");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_line
      // Track level; reset assumes deasserted line (pin high)
      always_ff @(posedge mclk) begin
        if (reset) begin
          last_q[i] <= 1'b1;
          edge_q[i] <= 1'b0;
        end else begin
          last_q[i] <= level[i];
          edge_q[i] <= level[i] ^ last_q[i];
        end
      end

      // Sticky flag; a change in the clearing cycle wins
      always_ff @(posedge mclk) begin
        if (reset) begin
          changed_q[i] <= 1'b0;
        end else if (level[i] ^ last_q[i]) begin
          changed_q[i] <= 1'b1; // RULE1
        end else if (clear) begin
          changed_q[i] <= 1'b0; // RULE11
        end
      end
    end
  endgenerate

endmodule

//--- logic/uas_aux_slice.sv
// Auxiliary register slice of the serial port: modem change flag, scratch, aliases, test
//
// Behaviour
// RULE1 - Clear-to-send change sets modem status bit zero
// RULE2 - Scratch byte at 0x1C, reset zero
// RULE3 - Low-power divisor low byte at 0x20
// RULE4 - Low-power divisor high byte at 0x24
// RULE5 - Alias reads return and pop receive byte
// RULE6 - Alias writes push transmit byte like normal
// RULE7 - Test enable bit at 0x70, option gated
// RULE8 - Master uses aliases only with divisor access clear
// RULE9 - Test mode reads return transmit head byte
// RULE10 - Test mode writes push byte with error flags
// RULE11 - Reading modem status clears change flag
`timescale 1ns/1ps
`include "uas_aux_regs.svh"
module uas_aux_slice #(
  parameter int ADDR_W = 8,
  parameter bit LOWPOWER_RX_OPTION = 1'b1,
  parameter bit SHADOW_OPTION = 1'b1,
  parameter bit FIFO_TEST_OPTION = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  // Modem control input, active low
  input wire logic cts_n,
  // Divisor latch access bit of line control
  input wire logic line_control_dlab,
  // Receive buffer side
  input wire logic [7:0] receive_buffer,
  input wire logic receive_valid,
  output logic receive_pop_q,
  // Transmit holding side
  input wire logic transmit_ready,
  output logic [7:0] transmit_holding_q,
  output logic transmit_push_q,
  // Test access to the buffers
  input wire logic [7:0] transmit_head,
  output logic test_mode_q,
  output logic [7:0] test_rx_data_q,
  output logic test_rx_parity_q,
  output logic test_rx_framing_q,
  output logic test_rx_push_q,
  // Low-power receive divisor
  output logic [15:0] lowpower_divisor_q,
  // Interrupt
  output logic irq_q
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------

  // The offsets need at least eight address bits
  generate
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
      $error("uas_aux_slice: ADDR_W must lie between 8 and 32");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------------

  // Map an address to the register it selects; used by reads and writes
  function automatic uas_pkg::uas_region_e decode(input logic [ADDR_W-1:0] addr);
    logic [7:0] low;
    logic high_zero;
    low = addr[7:0];
    high_zero = (addr >> 8) == '0;
    decode = uas_pkg::REGION_NONE;
    if (!high_zero || low[1:0] != 2'h0) begin
      // Off the map or not word aligned
      decode = uas_pkg::REGION_NONE;
    end else if (low == `UAS_OFF_MODEM_STATUS) begin
      decode = uas_pkg::REGION_MODEM;
    end else if (low == `UAS_OFF_SCRATCH) begin
      decode = uas_pkg::REGION_SCRATCH;
    end else if (low == `UAS_OFF_LP_DIV_LOW && LOWPOWER_RX_OPTION) begin
      decode = uas_pkg::REGION_LP_LOW;
    end else if (low == `UAS_OFF_LP_DIV_HIGH && LOWPOWER_RX_OPTION) begin
      decode = uas_pkg::REGION_LP_HIGH;
    end else if (low >= `UAS_OFF_ALIAS_FIRST && low <= `UAS_OFF_ALIAS_LAST
                 && SHADOW_OPTION) begin
      decode = uas_pkg::REGION_ALIAS;
    end else if (low == `UAS_OFF_TEST_ENABLE) begin
      decode = uas_pkg::REGION_TEST_EN;
    end else if (low == `UAS_OFF_TX_TEST_READ && FIFO_TEST_OPTION) begin
      decode = uas_pkg::REGION_TX_TEST;
    end else if (low == `UAS_OFF_RX_TEST_WRITE && FIFO_TEST_OPTION) begin
      decode = uas_pkg::REGION_RX_TEST;
    end else if (low == `UAS_OFF_INT_STATUS) begin
      decode = uas_pkg::REGION_INT_STAT;
    end else if (low == `UAS_OFF_INT_MASK) begin
      decode = uas_pkg::REGION_INT_MASK;
    end
  endfunction

  // Decoded region of the current access
  uas_pkg::uas_region_e region;
  // Qualified strobes per region of interest
  logic rd_modem;
  logic alias_rd;
  logic alias_wr;
  logic alias_clash;

  assign region = decode(reg_addr);
  assign rd_modem = reg_rd && region == uas_pkg::REGION_MODEM;
  // Aliases only answer while the divisor latch is not selected
  assign alias_rd = reg_rd && region == uas_pkg::REGION_ALIAS && !line_control_dlab; // RULE5
  assign alias_wr = reg_wr && region == uas_pkg::REGION_ALIAS && !line_control_dlab; // RULE6
  // A master that breaks the access order is flagged, not obeyed
  assign alias_clash = (reg_rd || reg_wr) && region == uas_pkg::REGION_ALIAS
                       && line_control_dlab; // RULE8

  // ----------------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------------

  // Scratch byte: pure storage, steers nothing
  uas_pkg::uas_byte_t scratch_byte_q;
  // Interrupt mask, same layout as status
  logic [`UAS_INT_BITS-1:0] int_mask_q;
  // Mask as it stands after this edge, so the output follows a mask write at once
  logic [`UAS_INT_BITS-1:0] int_mask_d;
  // Sticky interrupt status
  logic [`UAS_INT_BITS-1:0] int_status_q;

  // Scratch byte storage
  always_ff @(posedge mclk) begin
    if (reset) begin
      scratch_byte_q <= `UAS_RST_BYTE;
    end else if (reg_wr && region == uas_pkg::REGION_SCRATCH) begin
      scratch_byte_q <= reg_wdata[7:0]; // RULE2
    end
  end

  // Low-power divisor bytes; absent option leaves them at reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      lowpower_divisor_q <= {`UAS_RST_BYTE, `UAS_RST_BYTE};
    end else if (reg_wr && region == uas_pkg::REGION_LP_LOW) begin
      lowpower_divisor_q[7:0] <= reg_wdata[7:0]; // RULE3
    end else if (reg_wr && region == uas_pkg::REGION_LP_HIGH) begin
      lowpower_divisor_q[15:8] <= reg_wdata[7:0]; // RULE4
    end
  end

  // Test access enable; writes ignored without the test option
  always_ff @(posedge mclk) begin
    if (reset) begin
      test_mode_q <= `UAS_RST_TEST_ENABLE;
    end else if (reg_wr && region == uas_pkg::REGION_TEST_EN && FIFO_TEST_OPTION) begin
      test_mode_q <= reg_wdata[`UAS_TEST_ENABLE_BIT]; // RULE7
    end
  end

  // Interrupt mask
  always_ff @(posedge mclk) begin
    if (reset) begin
      int_mask_q <= `UAS_RST_INT;
    end else if (reg_wr && region == uas_pkg::REGION_INT_MASK) begin
      int_mask_q <= reg_wdata[`UAS_INT_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Clear-to-send change tracking
  // ----------------------------------------------------------------------

  // Sticky change flag and change pulse from the detector
  logic cts_changed_q;
  logic cts_edge_q;

  // Pin is taken as synchronous, so no synchroniser in front
  uas_change_detect #(
    .WIDTH(1)
  ) u_cts_detect (
    .mclk(mclk),
    .reset(reset),
    .level(cts_n),
    .clear(rd_modem),
    .changed_q(cts_changed_q),
    .edge_q(cts_edge_q)
  );

  // ----------------------------------------------------------------------
  // Interrupt status and output
  // ----------------------------------------------------------------------

  // Events of this cycle, one per status bit
  logic [`UAS_INT_BITS-1:0] int_event;
  // Bits software asks to clear
  logic [`UAS_INT_BITS-1:0] int_clear;

  always_comb begin
    int_event = `UAS_RST_INT;
    int_event[`UAS_INT_CTS] = cts_edge_q;
    int_event[`UAS_INT_DLAB_CLASH] = alias_clash;
    int_event[`UAS_INT_RX_EMPTY] = alias_rd && !receive_valid;
    int_event[`UAS_INT_TX_FULL] = alias_wr && !transmit_ready;
  end

  assign int_clear = (reg_wr && region == uas_pkg::REGION_INT_STAT) ?
                     reg_wdata[`UAS_INT_BITS-1:0] : `UAS_RST_INT;

  assign int_mask_d = (reg_wr && region == uas_pkg::REGION_INT_MASK) ?
                      reg_wdata[`UAS_INT_BITS-1:0] : int_mask_q;

  // Write one to clear; a new event in the same cycle survives
  always_ff @(posedge mclk) begin
    if (reset) begin
      int_status_q <= `UAS_RST_INT;
    end else begin
      int_status_q <= (int_status_q & ~int_clear) | int_event;
    end
  end

  // Level interrupt, registered so the output comes from a flop
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((int_status_q & ~int_clear) | int_event) & int_mask_d);
    end
  end

  // ----------------------------------------------------------------------
  // Buffer aliases
  // ----------------------------------------------------------------------

  // Pop the receive buffer once per alias read that found a byte
  always_ff @(posedge mclk) begin
    if (reset) begin
      receive_pop_q <= 1'b0;
    end else begin
      receive_pop_q <= alias_rd && receive_valid; // RULE5
    end
  end

  // Push a byte toward the transmitter; dropped when it cannot take it
  always_ff @(posedge mclk) begin
    if (reset) begin
      transmit_push_q <= 1'b0;
      transmit_holding_q <= `UAS_RST_BYTE;
    end else begin
      transmit_push_q <= alias_wr && transmit_ready; // RULE6
      if (alias_wr && transmit_ready) begin
        transmit_holding_q <= reg_wdata[7:0]; // RULE6
      end
    end
  end

  // ----------------------------------------------------------------------
  // Test access to the buffers
  // ----------------------------------------------------------------------

  // Injected receive byte with its error flags, one-cycle push
  always_ff @(posedge mclk) begin
    if (reset) begin
      test_rx_push_q <= 1'b0;
      test_rx_data_q <= `UAS_RST_BYTE;
      test_rx_parity_q <= 1'b0;
      test_rx_framing_q <= 1'b0;
    end else begin
      test_rx_push_q <= 1'b0;
      if (reg_wr && region == uas_pkg::REGION_RX_TEST && test_mode_q) begin
        test_rx_push_q <= 1'b1; // RULE10
        test_rx_data_q <= reg_wdata[7:0]; // RULE10
        test_rx_parity_q <= reg_wdata[`UAS_RXTEST_PARITY]; // RULE10
        test_rx_framing_q <= reg_wdata[`UAS_RXTEST_FRAMING]; // RULE10
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------

  // Value of the addressed register; zero for unmapped or write-only ones
  logic [31:0] read_word;

  always_comb begin
    read_word = `UAS_RST_WORD;
    case (region)
      uas_pkg::REGION_MODEM: begin
        // Only the clear-to-send bits live here; others read zero
        read_word[`UAS_MSTAT_CTS_CHANGED] = cts_changed_q; // RULE1
        read_word[`UAS_MSTAT_CTS_LEVEL] = !cts_n;
      end
      uas_pkg::REGION_SCRATCH: begin
        read_word[7:0] = scratch_byte_q; // RULE2
      end
      uas_pkg::REGION_LP_LOW: begin
        read_word[7:0] = lowpower_divisor_q[7:0]; // RULE3
      end
      uas_pkg::REGION_LP_HIGH: begin
        read_word[7:0] = lowpower_divisor_q[15:8]; // RULE4
      end
      uas_pkg::REGION_ALIAS: begin
        // Empty buffer or divisor access gives zero
        if (!line_control_dlab && receive_valid) begin
          read_word[7:0] = receive_buffer; // RULE5
        end
      end
      uas_pkg::REGION_TEST_EN: begin
        read_word[`UAS_TEST_ENABLE_BIT] = test_mode_q; // RULE7
      end
      uas_pkg::REGION_TX_TEST: begin
        // Valid only in test mode, else reads zero
        if (test_mode_q) begin
          read_word[7:0] = transmit_head; // RULE9
        end
      end
      uas_pkg::REGION_INT_STAT: begin
        read_word[`UAS_INT_BITS-1:0] = int_status_q;
      end
      uas_pkg::REGION_INT_MASK: begin
        read_word[`UAS_INT_BITS-1:0] = int_mask_q;
      end
      default: begin
        // Write-only and unmapped addresses read zero
        read_word = `UAS_RST_WORD;
      end
    endcase
  end

  // Read data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata_q <= `UAS_RST_WORD;
    end else if (reg_rd) begin
      reg_rdata_q <= read_word;
    end else begin
      reg_rdata_q <= `UAS_RST_WORD;
    end
  end

endmodule

//--- dv/uas_aux_slice_properties.sv
// Concurrent checks on the ports of the auxiliary register slice
`timescale 1ns/1ps
module uas_aux_slice_properties #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_q,
  // Buffer side
  input wire logic line_control_dlab,
  input wire logic [7:0] receive_buffer,
  input wire logic receive_valid,
  input wire logic receive_pop_q,
  input wire logic transmit_ready,
  input wire logic [7:0] transmit_holding_q,
  input wire logic transmit_push_q,
  input wire logic [7:0] transmit_head,
  // Test access and divisor
  input wire logic test_mode_q,
  input wire logic [7:0] test_rx_data_q,
  input wire logic test_rx_parity_q,
  input wire logic test_rx_framing_q,
  input wire logic test_rx_push_q,
  input wire logic [15:0] lowpower_divisor_q
);
  // ----
  // Decode helpers
  // ----
  logic [7:0] addr8; // Byte offset seen by the decoder
  logic alias_hit; // Aligned word inside the alias window
  assign addr8 = reg_addr[7:0];
  assign alias_hit = addr8 >= 8'h30 && addr8 <= 8'h6C && addr8[1:0] == 2'h0;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Idle cycles carry zero read data, so stale bytes never leak
  property p_idle;
    !reg_rd |=> reg_rdata_q == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_scr_hi;
    reg_rd && addr8 == 8'h1C |=> reg_rdata_q[31:8] == 24'h0;
  endproperty
  a_scr_hi: assert property (p_scr_hi) else $error("scratch upper bits set");
  property p_lp;
    (reg_wr && addr8 == 8'h20
      |=> {24'h0, lowpower_divisor_q[7:0]} == ($past(reg_wdata) & 32'hFF))
    and (reg_wr && addr8 == 8'h24
      |=> {24'h0, lowpower_divisor_q[15:8]} == ($past(reg_wdata) & 32'hFF));
  endproperty
  a_lp: assert property (p_lp) else $error("divisor byte not stored");
  property p_pop;
    reg_rd && alias_hit && !line_control_dlab && receive_valid
      |=> receive_pop_q && reg_rdata_q == {24'h0, $past(receive_buffer)};
  endproperty
  a_pop: assert property (p_pop) else $error("alias read wrong");
  property p_push;
    reg_wr && alias_hit && !line_control_dlab && transmit_ready
      |=> transmit_push_q && {24'h0, transmit_holding_q} == ($past(reg_wdata) & 32'hFF);
  endproperty
  a_push: assert property (p_push) else $error("alias write wrong");
  // Divisor access owns the window: no buffer traffic then
  property p_dlab;
    (reg_rd || reg_wr) && line_control_dlab |=> !receive_pop_q && !transmit_push_q;
  endproperty
  a_dlab: assert property (p_dlab) else $error("alias used with dlab");
  property p_test_en;
    reg_wr && addr8 == 8'h70 |=> {31'h0, test_mode_q} == ($past(reg_wdata) & 32'h1);
  endproperty
  a_test_en: assert property (p_test_en) else $error("test enable wrong");
  property p_rx_test;
    reg_wr && addr8 == 8'h78 && test_mode_q |=> test_rx_push_q
      && {22'h0, test_rx_framing_q, test_rx_parity_q, test_rx_data_q}
      == ($past(reg_wdata) & 32'h3FF);
  endproperty
  a_rx_test: assert property (p_rx_test) else $error("test push wrong");
  property p_tx_test;
    reg_rd && addr8 == 8'h74 && test_mode_q |=> reg_rdata_q == {24'h0, $past(transmit_head)};
  endproperty
  a_tx_test: assert property (p_tx_test) else $error("test read wrong");
endmodule

//--- dv/uas_far_model.sv
// Remote serial device model: clear-to-send line and byte buffers
`timescale 1ns/1ps
module uas_far_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Bench controls
  input wire logic cts_req,
  input wire logic rx_fill,
  input wire logic tx_stall,
  // Block side
  input wire logic receive_pop_q,
  input wire logic transmit_push_q,
  input wire logic [7:0] transmit_holding_q,
  output logic cts_n,
  output logic [7:0] receive_buffer,
  output logic receive_valid,
  output logic transmit_ready,
  output logic [7:0] transmit_head
);
  logic [7:0] rx_q; // Byte at the receive head
  // Pops advance the receive stream, pushes land at the transmit head
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_q <= 8'hA0;
      transmit_head <= 8'h00;
    end else begin
      if (receive_pop_q) begin
        rx_q <= rx_q + 8'h01;
      end
      if (transmit_push_q) begin
        transmit_head <= transmit_holding_q;
      end
    end
  end
  // Empty buffer shows the inverse byte, so a wrong read never matches
  always_comb begin
    cts_n = ~cts_req;
    receive_valid = rx_fill;
    receive_buffer = rx_fill ? rx_q : ~rx_q;
    transmit_ready = ~tx_stall;
  end
endmodule

//--- dv/uas_aux_slice_tb_top.sv
// Self-checking bench of the auxiliary register slice
`timescale 1ns/1ps
module uas_aux_slice_tb_top;
  // ----
  // Signals
  // ----
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic line_control_dlab = 1'b0;
  logic cts_req = 1'b0; // Far side asserts clear-to-send
  logic rx_fill = 1'b0; // Far side offers a byte
  logic tx_stall = 1'b0; // Far side refuses bytes
  logic [31:0] reg_rdata_q;
  logic cts_n, receive_valid, transmit_ready, receive_pop_q, transmit_push_q;
  logic [7:0] receive_buffer, transmit_head, transmit_holding_q, test_rx_data_q;
  logic test_mode_q, test_rx_parity_q, test_rx_framing_q, test_rx_push_q, irq_q;
  logic [15:0] lowpower_divisor_q;
  int errors = 0;
  int check_count = 0;
  typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic [31:0] exp;} uas_row_s;
  // Write then read back; last scratch row stays for the second reset
  uas_row_s rows [8] = '{'{8'h1C, 32'hFFFFFFA5, 32'hA5}, '{8'h20, 32'h12345678, 32'h78},
    '{8'h24, 32'hABCDEF9C, 32'h9C}, '{8'h70, 32'hFFFFFFFF, 32'h1}, '{8'h70, 32'h0, 32'h0},
    '{8'h8C, 32'hFFFFFFFF, 32'h0}, '{8'h1D, 32'hFFFFFFFF, 32'h0}, '{8'h1C, 32'h3C, 32'h3C}};
  // ----
  // Design and far side
  // ----
  uas_aux_slice #(.ADDR_W(8)) DUT (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .cts_n(cts_n), .line_control_dlab(line_control_dlab), .receive_buffer(receive_buffer),
    .receive_valid(receive_valid), .receive_pop_q(receive_pop_q),
    .transmit_ready(transmit_ready), .transmit_holding_q(transmit_holding_q),
    .transmit_push_q(transmit_push_q), .transmit_head(transmit_head),
    .test_mode_q(test_mode_q), .test_rx_data_q(test_rx_data_q),
    .test_rx_parity_q(test_rx_parity_q), .test_rx_framing_q(test_rx_framing_q),
    .test_rx_push_q(test_rx_push_q), .lowpower_divisor_q(lowpower_divisor_q), .irq_q(irq_q));
  uas_far_model u_far (.mclk(mclk), .reset(reset), .cts_req(cts_req), .rx_fill(rx_fill),
    .tx_stall(tx_stall), .receive_pop_q(receive_pop_q), .transmit_push_q(transmit_push_q),
    .transmit_holding_q(transmit_holding_q), .cts_n(cts_n), .receive_buffer(receive_buffer),
    .receive_valid(receive_valid), .transmit_ready(transmit_ready),
    .transmit_head(transmit_head));
  // 200 MHz clock
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand one cycle only, so sample just after the answer edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata_q, exp);
  endtask
  task automatic step;
    @(posedge mclk);
    #1;
  endtask
  task automatic do_reset;
    @(posedge mclk);
    reset <= 1'b1;
    cts_req <= 1'b0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
  endtask
  task automatic reset_chk;
    logic [7:0] offs [6];
    offs = '{8'h1C, 8'h20, 8'h24, 8'h70, 8'h90, 8'h94};
    foreach (offs[i]) rd_chk(offs[i], 32'h0);
    check({15'h0, lowpower_divisor_q, irq_q}, 32'h0);
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    $display("watchdog expired");
    print_verdict();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    do_reset();
    reset_chk();
    $display("test reset values done");
    foreach (rows[i]) begin
      bus_wr(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    check({16'h0, lowpower_divisor_q}, 32'h9C78);
    $display("test register rows done");
    // Change flag sets, then clears on read
    rd_chk(8'h18, 32'h0);
    @(posedge mclk);
    cts_req <= 1'b1;
    rd_chk(8'h18, 32'h11);
    rd_chk(8'h18, 32'h10);
    $display("test clear-to-send done");
    // Alias reads consume bytes; divisor access blocks them
    @(posedge mclk);
    rx_fill <= 1'b1;
    rd_chk(8'h30, 32'hA0);
    rd_chk(8'h6C, 32'hA1);
    @(posedge mclk);
    line_control_dlab <= 1'b1;
    rd_chk(8'h40, 32'h0);
    bus_wr(8'h40, 32'h77);
    @(posedge mclk);
    line_control_dlab <= 1'b0;
    rd_chk(8'h40, 32'hA2);
    @(posedge mclk);
    rx_fill <= 1'b0;
    rd_chk(8'h34, 32'h0);
    // Alias writes reach the transmit head, seen through the test port
    bus_wr(8'h70, 32'h1);
    bus_wr(8'h6C, 32'hFFFFFFC3);
    rd_chk(8'h74, 32'hC3);
    @(posedge mclk);
    tx_stall <= 1'b1;
    bus_wr(8'h50, 32'h11);
    rd_chk(8'h74, 32'hC3);
    bus_wr(8'h78, 32'h35A);
    #1;
    check({22'h0, test_rx_framing_q, test_rx_parity_q, test_rx_data_q}, 32'h35A);
    bus_wr(8'h70, 32'h0);
    rd_chk(8'h74, 32'h0);
    $display("test alias and test port done");
    // Sticky events, mask and write-one-to-clear
    rd_chk(8'h90, 32'hF);
    check({31'h0, irq_q}, 32'h0);
    bus_wr(8'h94, 32'h2);
    step();
    check({31'h0, irq_q}, 32'h1);
    bus_wr(8'h90, 32'h2);
    step();
    check({31'h0, irq_q}, 32'h0);
    rd_chk(8'h90, 32'hD);
    $display("test interrupt done");
    do_reset();
    reset_chk();
    $display("test second reset done");
    print_verdict();
  end
endmodule
bind uas_aux_slice uas_aux_slice_properties #(.ADDR_W(ADDR_W)) u_props (.mclk(mclk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .line_control_dlab(line_control_dlab),
  .receive_buffer(receive_buffer), .receive_valid(receive_valid),
  .receive_pop_q(receive_pop_q), .transmit_ready(transmit_ready),
  .transmit_holding_q(transmit_holding_q), .transmit_push_q(transmit_push_q),
  .transmit_head(transmit_head), .test_mode_q(test_mode_q), .test_rx_data_q(test_rx_data_q),
  .test_rx_parity_q(test_rx_parity_q), .test_rx_framing_q(test_rx_framing_q),
  .test_rx_push_q(test_rx_push_q), .lowpower_divisor_q(lowpower_divisor_q));
